// file: src/lane_metaframe_pcs.sv
//Behaviour
// - Word boundary lock after 64 legal sync headers in a row.
// - Locked: 16 bad headers within 64 words drops lock, search restarts.
// - Word lock state is driven out to user logic.
// - Transmit metaframe length programmable from 5 to 8191 words.
// - Generator emits sync, scrambler state, skip, diagnostic words plus payload.
// - Frame lock after four sync words at expected spacing.
// - Lose frame lock on four bad sync or three scrambler mismatches.
// - Metaframe lock status is driven out to user logic.
// - Payload inverted as needed to hold running disparity within 96 bits.
// - Bit 66 flags inversion; receiver restores bits 63 to 0.
// - Scrambler and descrambler use 58-bit LFSR x^58+x^39+1.
// - Sync words, scrambler state words and framing bits pass unscrambled.
// - Each lane's scrambler starts from its own seed at reset.
// - Receiver loads descrambler from received scrambler state words.
// - Lane ready, frame lock and CRC error outputs toward user logic.
// - Readable status for word lock, frame lock, sync, scrambler, CRC errors.
// - Fixed skip after scrambler state; extra skips when transmit FIFO empty.
// - Received skip words are kept and passed to the MAC.
// - CRC-32 per metaframe carried in diagnostic word, checked on receive.
// - All four control word types are forwarded to the MAC.
// - Elastic transmit and receive FIFOs with handshake and backpressure.
// - 64-bit data word plus one control bit crosses to user logic.
`timescale 1ns/1ps
`include "lane_pcs_regs.svh"
module lane_metaframe_pcs #(
	parameter logic [57:0] SEED = 58'h0123456789abcde,
	parameter int FIFO_AW = 4
) (
	input wire logic I_CLOCK,
	input wire logic I_NRST,
	input wire logic [63:0] I_TX_DATA,
	input wire logic I_TX_CTRL,
	input wire logic I_TX_VALID,
	output logic O_TX_READY,
	output logic [66:0] O_TX_WORD,
	input wire logic [66:0] I_RX_WORD,
	output logic [63:0] O_RX_DATA,
	output logic O_RX_CTRL,
	output logic O_RX_VALID,
	input wire logic I_RX_READY,
	output logic O_WORD_LOCK,
	output logic O_FRAME_LOCK,
	output logic O_LANE_READY,
	output logic O_CRC_ERR,
	input wire logic [3:0] I_ADDR,
	input wire logic [31:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [31:0] O_RDATA
);
	typedef struct packed {
		logic [12:0] mf_len;
		logic [3:0] ev;
		logic [31:0] rdata;
		logic [12:0] tx_pos;
		logic [57:0] tx_scr;
		logic [31:0] tx_crc;
		logic [8:0] tx_disp;
		logic [66:0] tx_word;
		logic [66:0] blk_prev;
		logic [6:0] slip;
		lane_pcs_pkg::bs_state_t bs;
		logic [5:0] good;
		logic [5:0] win;
		logic [4:0] bad;
		lane_pcs_pkg::fs_state_t fs;
		logic [12:0] rx_pos;
		logic [2:0] fcnt;
		logic [1:0] mcnt;
		logic [57:0] rx_scr;
		logic [31:0] rx_crc;
		logic crc_err;
	} st_t;
	st_t q;
	st_t d;

	function automatic logic [6:0] pop64(input logic [63:0] v);
		logic [6:0] n;
		n = 7'h00;
		for (int i = 0; i < 64; i++) begin
			n = n + {6'h00, v[i]};
		end
		return n;
	endfunction

	logic [12:0] len_last;
	logic tx_last;
	logic tx_pop;
	logic tx_scr_en;
	logic [1:0] tx_hdr;
	logic [63:0] tx_plain;
	logic [31:0] tx_crc_in;
	logic [57:0] tx_scr_o;
	logic [31:0] tx_crc_o;
	logic [63:0] tx_out;
	logic txf_valid;
	logic [64:0] txf_data;

	logic [133:0] rx_pair;
	logic [66:0] rx_w;
	logic hdr_ok;
	logic rx_ctrl;
	logic [63:0] rx_raw;
	logic is_sync;
	logic is_ss;
	logic rx_at0;
	logic [57:0] rx_scr_in;
	logic [31:0] rx_crc_in;
	logic [57:0] rx_scr_o;
	logic [31:0] rx_crc_o;
	logic [63:0] rx_out;
	logic rxf_push;
	logic rxf_ready;

	// Lengths below the legal floor are lifted to it rather than producing a broken frame
	assign len_last = ((q.mf_len < `MF_LEN_MIN) ? `MF_LEN_MIN : q.mf_len) - 13'h0001;
	// A shortened length takes effect at once instead of running out a frame of 8191 words
	assign tx_last = q.tx_pos >= len_last;

	lane_fifo #(.W(65), .AW(FIFO_AW)) u_tx_fifo (
		.i_clk(I_CLOCK),
		.i_nrst(I_NRST),
		.i_wr_valid(I_TX_VALID),
		.o_wr_ready(O_TX_READY),
		.i_wr_data({I_TX_CTRL, I_TX_DATA}),
		.o_rd_valid(txf_valid),
		.i_rd_ready(tx_pop),
		.o_rd_data(txf_data)
	);

	always_comb begin
		tx_pop = 1'b0;
		tx_scr_en = 1'b1;
		tx_hdr = `HDR_CTRL;
		tx_plain = `SKIP_WORD;
		tx_crc_in = (q.tx_pos == `POS_SYNC) ? `CRC_INIT : q.tx_crc;
		if (q.tx_pos == `POS_SYNC) begin
			tx_plain = `SYNC_WORD;
			tx_scr_en = 1'b0;
		end else if (q.tx_pos == `POS_SS) begin
			tx_plain = {`TYPE_SS, q.tx_scr};
			tx_scr_en = 1'b0;
		end else if (q.tx_pos == `POS_SKIP) begin
			tx_plain = `SKIP_WORD;
		end else if (tx_last) begin
			tx_plain = {`DIAG_HEAD, q.tx_crc};
		end else if (txf_valid) begin
			tx_pop = 1'b1;
			tx_plain = txf_data[63:0];
			tx_hdr = txf_data[64] ? `HDR_CTRL : `HDR_DATA;
		end
		// An empty slot becomes an extra skip so the line never stalls
	end

	lane_word_math #(.CRC_AFTER(1'b0)) u_tx_math (
		.i_scr(q.tx_scr),
		.i_crc(tx_crc_in),
		.i_din(tx_plain),
		.i_scramble(tx_scr_en),
		.o_scr(tx_scr_o),
		.o_crc(tx_crc_o),
		.o_dout(tx_out)
	);

	// Receive word taken from the gearbox on this clock, no resync needed
	assign rx_pair = {I_RX_WORD, q.blk_prev};
	assign rx_w = rx_pair[q.slip +: 67];
	assign hdr_ok = rx_w[65] ^ rx_w[64];
	assign rx_ctrl = rx_w[65:64] == `HDR_CTRL;
	assign rx_raw = rx_w[66] ? ~rx_w[63:0] : rx_w[63:0];
	assign is_sync = rx_ctrl && rx_raw[63:58] == `TYPE_SYNC;
	// State words only count in their slot, a scrambled word can mimic the type code
	assign is_ss = rx_ctrl && rx_raw[63:58] == `TYPE_SS && q.fs != lane_pcs_pkg::FS_HUNT && q.rx_pos == `POS_SS;
	assign rx_at0 = (q.fs == lane_pcs_pkg::FS_HUNT) ? is_sync : (q.rx_pos == `POS_SYNC);
	assign rx_scr_in = is_ss ? rx_raw[57:0] : q.rx_scr;
	assign rx_crc_in = rx_at0 ? `CRC_INIT : q.rx_crc;

	lane_word_math #(.CRC_AFTER(1'b1)) u_rx_math (
		.i_scr(rx_scr_in),
		.i_crc(rx_crc_in),
		.i_din(rx_raw),
		.i_scramble(!(rx_at0 || is_ss)),
		.o_scr(rx_scr_o),
		.o_crc(rx_crc_o),
		.o_dout(rx_out)
	);

	// Every word, skip and control words included, goes to the MAC while frame and word locked
	assign rxf_push = q.fs == lane_pcs_pkg::FS_LOCK && q.bs == lane_pcs_pkg::BS_LOCK;

	lane_fifo #(.W(65), .AW(FIFO_AW)) u_rx_fifo (
		.i_clk(I_CLOCK),
		.i_nrst(I_NRST),
		.i_wr_valid(rxf_push),
		.o_wr_ready(rxf_ready),
		.i_wr_data({rx_ctrl, rx_out}),
		.o_rd_valid(O_RX_VALID),
		.i_rd_ready(I_RX_READY),
		.o_rd_data({O_RX_CTRL, O_RX_DATA})
	);

	always_comb begin
		logic [3:0] ev_set;
		logic [3:0] ev_clr;
		logic [6:0] ones;
		int rd;
		int dn;
		logic inv;
		logic [4:0] bad_n;
		ev_set = 4'h0;
		ev_clr = 4'h0;
		ones = pop64(tx_out);
		rd = int'($signed(q.tx_disp));
		dn = 2 * int'(ones) - `DISP_NEUTRAL;
		inv = (rd > 0) == (dn > 0);
		bad_n = q.bad + {4'h0, !hdr_ok};
		d = q;

		// Register port
		d.rdata = 32'h00000000;
		if (I_WR && I_ADDR == `ADDR_CTRL) begin
			d.mf_len = I_WDATA[12:0];
		end
		if (I_WR && I_ADDR == `ADDR_EVENTS) begin
			ev_clr = I_WDATA[3:0];
		end
		if (I_RD) begin
			case (I_ADDR)
				`ADDR_CTRL: d.rdata = {19'h00000, q.mf_len};
				`ADDR_STATUS: begin
					d.rdata[`ST_WLOCK] = q.bs == lane_pcs_pkg::BS_LOCK;
					d.rdata[`ST_FLOCK] = q.fs == lane_pcs_pkg::FS_LOCK;
				end
				`ADDR_EVENTS: d.rdata = {28'h0000000, q.ev};
				default: d.rdata = 32'h00000000;
			endcase
		end

		// Transmit
		d.tx_pos = tx_last ? `POS_SYNC : q.tx_pos + 13'h0001;
		d.tx_scr = tx_scr_o;
		d.tx_crc = tx_crc_o;
		d.tx_word = {inv, tx_hdr, inv ? ~tx_out : tx_out};
		d.tx_disp = 9'(rd + (inv ? -dn : dn));

		// Block synchronizer
		d.blk_prev = I_RX_WORD;
		case (q.bs)
			lane_pcs_pkg::BS_HUNT: begin
				if (hdr_ok) begin
					d.good = q.good + 6'h01;
					if (q.good == `BLK_GOOD_LAST) begin
						d.bs = lane_pcs_pkg::BS_LOCK;
						d.win = 6'h00;
						d.bad = 5'h00;
					end
				end else begin
					d.good = 6'h00;
					d.slip = (q.slip == `SLIP_LAST) ? 7'h00 : q.slip + 7'h01;
				end
			end
			lane_pcs_pkg::BS_LOCK: begin
				d.win = q.win + 6'h01;
				d.bad = (q.win == `BLK_WIN_LAST) ? 5'h00 : bad_n;
				if (bad_n == `BLK_BAD_MAX) begin
					d.bs = lane_pcs_pkg::BS_HUNT;
					d.good = 6'h00;
					d.slip = (q.slip == `SLIP_LAST) ? 7'h00 : q.slip + 7'h01;
				end
			end
			default: d.bs = lane_pcs_pkg::BS_HUNT;
		endcase

		// Frame synchronizer
		d.rx_scr = rx_scr_o;
		d.rx_crc = rx_crc_o;
		d.rx_pos = (q.rx_pos == len_last) ? `POS_SYNC : q.rx_pos + 13'h0001;
		case (q.fs)
			lane_pcs_pkg::FS_HUNT: begin
				if (is_sync) begin
					d.fs = lane_pcs_pkg::FS_CHECK;
					d.rx_pos = `POS_SS;
					d.fcnt = 3'h1;
				end
			end
			lane_pcs_pkg::FS_CHECK: begin
				if (q.rx_pos == `POS_SYNC) begin
					if (!is_sync) begin
						d.fs = lane_pcs_pkg::FS_HUNT;
					end else if (q.fcnt + 3'h1 == `FS_SYNC_GOOD) begin
						d.fs = lane_pcs_pkg::FS_LOCK;
						d.fcnt = 3'h0;
						d.mcnt = 2'h0;
					end else begin
						d.fcnt = q.fcnt + 3'h1;
					end
				end
			end
			lane_pcs_pkg::FS_LOCK: begin
				if (q.rx_pos == `POS_SYNC) begin
					d.fcnt = is_sync ? 3'h0 : q.fcnt + 3'h1;
					if (!is_sync) begin
						ev_set[`EV_SYNC] = 1'b1;
					end
					if (!is_sync && q.fcnt + 3'h1 == `FS_SYNC_BAD) begin
						d.fs = lane_pcs_pkg::FS_HUNT;
					end
				end
				if (q.rx_pos == `POS_SS) begin
					// Mismatch judged against the local state before it is overwritten
					if (!is_ss || rx_raw[57:0] != q.rx_scr) begin
						ev_set[`EV_SCR] = 1'b1;
						d.mcnt = q.mcnt + 2'h1;
						if (q.mcnt + 2'h1 == `FS_SCR_BAD) begin
							d.fs = lane_pcs_pkg::FS_HUNT;
						end
					end else begin
						d.mcnt = 2'h0;
					end
				end
				if (q.rx_pos == len_last) begin
					d.crc_err = rx_out[31:0] != q.rx_crc;
					ev_set[`EV_CRC] = rx_out[31:0] != q.rx_crc;
				end
				if (!rxf_ready) begin
					ev_set[`EV_OVF] = 1'b1;
				end
			end
			default: d.fs = lane_pcs_pkg::FS_HUNT;
		endcase
		// Frame lock cannot outlive the word boundary it was found on
		if (q.bs != lane_pcs_pkg::BS_LOCK) begin
			d.fs = lane_pcs_pkg::FS_HUNT;
		end
		if (d.fs != lane_pcs_pkg::FS_LOCK) begin
			d.crc_err = 1'b0;
		end

		// Set wins over a simultaneous clear
		d.ev = (q.ev & ~ev_clr) | ev_set;
	end

	always_ff @(posedge I_CLOCK) begin
		if (!I_NRST) begin
			q <= '0;
			q.mf_len <= `MF_LEN_RST;
			q.tx_scr <= SEED;
			q.rx_scr <= SEED;
			q.bs <= lane_pcs_pkg::BS_HUNT;
			q.fs <= lane_pcs_pkg::FS_HUNT;
		end else begin
			q <= d;
		end
	end

	assign O_TX_WORD = q.tx_word;
	assign O_WORD_LOCK = q.bs == lane_pcs_pkg::BS_LOCK;
	assign O_FRAME_LOCK = q.fs == lane_pcs_pkg::FS_LOCK;
	assign O_LANE_READY = O_WORD_LOCK && O_FRAME_LOCK;
	assign O_CRC_ERR = q.crc_err;
	assign O_RDATA = q.rdata;
endmodule // lane_metaframe_pcs

// file: src/lane_pcs_regs.svh
`ifndef LANE_PCS_REGS_SVH
`define LANE_PCS_REGS_SVH
`define ADDR_CTRL 4'h0
`define ADDR_STATUS 4'h4
`define ADDR_EVENTS 4'h8
`define MF_LEN_RST 13'h0800
`define MF_LEN_MIN 13'h0005
`define POS_SYNC 13'h0000
`define POS_SS 13'h0001
`define POS_SKIP 13'h0002
`define HDR_DATA 2'h1
`define HDR_CTRL 2'h2
`define TYPE_SYNC 6'h1e
`define TYPE_SS 6'h0a
`define TYPE_DIAG 6'h19
`define SYNC_WORD 64'h78f678f678f678f6
`define SKIP_WORD 64'h1e1e1e1e1e1e1e1e
`define DIAG_HEAD 32'h64000000
`define CRC_POLY 32'h1edc6f41
`define CRC_INIT 32'hffffffff
`define SCR_TAP_HI 57
`define SCR_TAP_LO 38
`define BLK_GOOD_LAST 6'h3f
`define BLK_WIN_LAST 6'h3f
`define BLK_BAD_MAX 5'h10
`define SLIP_LAST 7'h42
`define FS_SYNC_GOOD 3'h4
`define FS_SYNC_BAD 3'h4
`define FS_SCR_BAD 2'h3
`define DISP_NEUTRAL 65
`define ST_WLOCK 0
`define ST_FLOCK 1
`define EV_SYNC 0
`define EV_SCR 1
`define EV_CRC 2
`define EV_OVF 3
`endif

// file: src/lane_pcs_pkg.sv
package lane_pcs_pkg;
	typedef enum logic [1:0] {BS_HUNT = 2'b01, BS_LOCK = 2'b10} bs_state_t;
	typedef enum logic [2:0] {FS_HUNT = 3'b001, FS_CHECK = 3'b010, FS_LOCK = 3'b100} fs_state_t;
endpackage

// file: src/lane_fifo.sv
`timescale 1ns/1ps
module lane_fifo #(
	parameter int W = 65,
	parameter int AW = 4
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_wr_valid,
	output logic o_wr_ready,
	input wire logic [W-1:0] i_wr_data,
	output logic o_rd_valid,
	input wire logic i_rd_ready,
	output logic [W-1:0] o_rd_data
);
	typedef struct packed {
		logic [(1<<AW)-1:0][W-1:0] mem;
		logic [AW:0] wp;
		logic [AW:0] rp;
		logic ov;
		logic [W-1:0] od;
	} fifo_st_t;
	fifo_st_t q;
	fifo_st_t d;
	logic [AW:0] used;
	logic full;
	assign used = q.wp - q.rp;
	assign full = used[AW];
	assign o_wr_ready = !full;
	assign o_rd_valid = q.ov;
	assign o_rd_data = q.od;
	always_comb begin
		d = q;
		if (i_wr_valid && !full) begin
			d.mem[q.wp[AW-1:0]] = i_wr_data;
			d.wp = q.wp + 1'b1;
		end
		if (i_rd_ready) begin
			d.ov = 1'b0;
		end
		// Output stage refills only when drained, so a stalled reader really fills the memory
		if ((!q.ov || i_rd_ready) && used != '0) begin
			d.od = q.mem[q.rp[AW-1:0]];
			d.ov = 1'b1;
			d.rp = q.rp + 1'b1;
		end
	end
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule // lane_fifo

// file: src/lane_word_math.sv
`timescale 1ns/1ps
`include "lane_pcs_regs.svh"
module lane_word_math #(
	parameter bit CRC_AFTER = 1'b0
) (
	input wire logic [57:0] i_scr,
	input wire logic [31:0] i_crc,
	input wire logic [63:0] i_din,
	input wire logic i_scramble,
	output logic [57:0] o_scr,
	output logic [31:0] o_crc,
	output logic [63:0] o_dout
);
	always_comb begin
		logic [57:0] s;
		logic [31:0] c;
		logic [63:0] m;
		logic fb;
		s = i_scr;
		c = i_crc;
		m = i_din;
		fb = 1'b0;
		// Additive LFSR advances on every word so both ends stay in step
		for (int i = 63; i >= 0; i--) begin
			fb = s[`SCR_TAP_HI] ^ s[`SCR_TAP_LO];
			m[i] = i_din[i] ^ (i_scramble & fb);
			s = {s[56:0], fb};
		end
		for (int i = 63; i >= 0; i--) begin
			fb = c[31] ^ (CRC_AFTER ? m[i] : i_din[i]);
			c = {c[30:0], 1'b0} ^ (fb ? `CRC_POLY : 32'h00000000);
		end
		o_scr = s;
		o_crc = c;
		o_dout = m;
	end
endmodule // lane_word_math

// file: test/lane_pcs_chk_sva.sv
`timescale 1ns/1ps
`include "lane_pcs_regs.svh"
module lane_pcs_chk (
	input wire logic I_CLOCK,
	input wire logic I_NRST,
	input wire logic [66:0] O_TX_WORD,
	input wire logic [63:0] O_RX_DATA,
	input wire logic O_RX_VALID,
	input wire logic I_RX_READY,
	input wire logic O_WORD_LOCK,
	input wire logic O_FRAME_LOCK,
	input wire logic O_LANE_READY,
	input wire logic O_CRC_ERR,
	input wire logic [3:0] I_ADDR,
	input wire logic I_RD,
	input wire logic [31:0] O_RDATA
);
	default clocking @(posedge I_CLOCK); endclocking
	default disable iff (!I_NRST);
	logic [15:0] hunt_q;
	logic [15:0] held_q;
	logic sync_seen;
	logic [5:0] ss_type;
	logic run_q;
	int disp_q;
	assign sync_seen = O_TX_WORD[65:64] == `HDR_CTRL && (O_TX_WORD[63:0] ^ {64{O_TX_WORD[66]}}) == `SYNC_WORD;
	assign ss_type = O_TX_WORD[63:58] ^ {6{O_TX_WORD[66]}};
	// Hunting time is counted from reset or loss of lock, so a relock is held to the same figure
	always_ff @(posedge I_CLOCK) begin
		hunt_q <= (!I_NRST || O_WORD_LOCK) ? 16'h0 : hunt_q + 16'h1;
		held_q <= O_WORD_LOCK ? held_q + 16'h1 : 16'h0;
		// Line disparity rebuilt from all 67 bits; the reset pattern of the first cycle is skipped
		run_q <= I_NRST;
		disp_q <= (!I_NRST || !run_q) ? 0 : disp_q + 2 * $countones(O_TX_WORD) - 67;
	end
	chk_disp_bound: assert property (disp_q >= -96 && disp_q <= 96)
		else $error("running disparity out of bounds");
	chk_ready_and: assert property (O_LANE_READY == (O_WORD_LOCK && O_FRAME_LOCK))
		else $error("lane ready differs from the two locks");
	chk_wlock_time: assert property ($rose(O_WORD_LOCK) |-> hunt_q >= 16'd64)
		else $error("word lock came too early");
	chk_flock_after: assert property ($rose(O_FRAME_LOCK) |-> O_WORD_LOCK && held_q >= 16'd15)
		else $error("frame lock without four sync words");
	chk_wdrop_flock: assert property ($fell(O_WORD_LOCK) |=> !O_FRAME_LOCK)
		else $error("frame lock kept after word lock loss");
	chk_reset_clr: assert property ($rose(I_NRST) |-> !O_WORD_LOCK && !O_FRAME_LOCK && !O_RX_VALID)
		else $error("locks not cleared by reset");
	chk_crc_scope: assert property (!O_FRAME_LOCK |-> !O_CRC_ERR)
		else $error("crc error outside frame lock");
	chk_rd_idle: assert property (!$past(I_RD) |-> O_RDATA == 32'h0)
		else $error("read data outside read slot");
	chk_status_rd: assert property ($past(I_RD) && $past(I_ADDR) == `ADDR_STATUS |->
		O_RDATA == {30'h0, $past(O_FRAME_LOCK), $past(O_WORD_LOCK)})
		else $error("status read wrong");
	chk_tx_hdr: assert property ($past(I_NRST) |-> O_TX_WORD[65] != O_TX_WORD[64])
		else $error("illegal transmit header");
	chk_sync_state: assert property (sync_seen |=> ss_type == `TYPE_SS)
		else $error("state word does not follow sync");
	chk_rx_hold: assert property (O_RX_VALID && !I_RX_READY |=> O_RX_VALID && $stable(O_RX_DATA))
		else $error("receive head changed while stalled");
	cover property ($rose(O_FRAME_LOCK));
	cover property ($fell(O_WORD_LOCK));
	cover property (O_RX_VALID && !I_RX_READY);
	cover property ($rose(O_CRC_ERR));
endmodule // lane_pcs_chk
bind lane_metaframe_pcs lane_pcs_chk chk_i (.I_CLOCK, .I_NRST, .O_TX_WORD, .O_RX_DATA, .O_RX_VALID, .I_RX_READY,
	.O_WORD_LOCK, .O_FRAME_LOCK, .O_LANE_READY, .O_CRC_ERR, .I_ADDR, .I_RD, .O_RDATA);

// file: test/lane_far_end.sv
`timescale 1ns/1ps
module lane_far_end (
	input wire logic i_clk,
	input wire logic [66:0] i_line,
	input wire logic i_break,
	input wire logic i_stall,
	input wire logic i_flip,
	output logic [66:0] o_line,
	output logic o_ready
);
	logic [3:0] stall_q = 4'h0;
	// Words arrive every cycle, so only a short stall is survivable by the receive FIFO
	always @(posedge i_clk) begin
		o_line <= (i_break ? {i_line[66], 2'b11, i_line[63:0]} : i_line) ^ {66'h0, i_flip};
		stall_q <= i_stall ? 4'h8 : (stall_q != 4'h0 ? stall_q - 4'h1 : 4'h0);
	end
	// Control words are popped too, deskew is left to this side
	assign o_ready = stall_q == 4'h0;
endmodule // lane_far_end

// file: test/lane_metaframe_pcs_tb.sv
`timescale 1ns/1ps
`include "lane_pcs_regs.svh"
module lane_metaframe_pcs_tb;
	logic I_CLOCK = 1'b0;
	logic I_NRST = 1'b0;
	logic [63:0] I_TX_DATA = 64'h0;
	logic I_TX_CTRL = 1'b0;
	logic I_TX_VALID = 1'b0;
	logic [3:0] I_ADDR = 4'h0;
	logic [31:0] I_WDATA = 32'h0;
	logic I_WR = 1'b0;
	logic I_RD = 1'b0;
	logic brk = 1'b0;
	logic stall = 1'b0;
	logic flip = 1'b0;
	logic [66:0] tx_w, rx_w;
	logic [63:0] rx_d;
	logic rx_c, rx_v, rx_r, tx_r, wlock, flock, lrdy, crc;
	logic [31:0] rd;
	int n_mismatch = 0;
	int check_count = 0;
	int cyc = 0;
	int last_sync = 0;
	int n_ctl = 0;
	logic gap_on = 1'b0;
	logic [63:0] rxq[$];
	always #5 I_CLOCK = ~I_CLOCK;
	lane_metaframe_pcs dut (.I_CLOCK, .I_NRST, .I_TX_DATA, .I_TX_CTRL, .I_TX_VALID, .O_TX_READY(tx_r),
		.O_TX_WORD(tx_w), .I_RX_WORD(rx_w), .O_RX_DATA(rx_d), .O_RX_CTRL(rx_c), .O_RX_VALID(rx_v),
		.I_RX_READY(rx_r), .O_WORD_LOCK(wlock), .O_FRAME_LOCK(flock), .O_LANE_READY(lrdy),
		.O_CRC_ERR(crc), .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA(rd));
	lane_far_end far (.i_clk(I_CLOCK), .i_line(tx_w), .i_break(brk), .i_stall(stall), .i_flip(flip), .o_line(rx_w),
		.o_ready(rx_r));
	task automatic check(input logic [66:0] seen, input logic [66:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge I_CLOCK);
		I_WR <= 1'b1;
		I_ADDR <= a;
		I_WDATA <= d;
		@(posedge I_CLOCK);
		I_WR <= 1'b0;
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
		@(posedge I_CLOCK);
		I_RD <= 1'b1;
		I_ADDR <= a;
		@(posedge I_CLOCK);
		I_RD <= 1'b0;
		#1 check(67'(rd), 67'(e));
	endtask
	function automatic logic pick(input int k);
		return k == 0 ? wlock : (k == 1 ? flock : crc);
	endfunction
	task automatic wait_for(input int k, input int lim);
		for (int n = 0; n < lim && pick(k) !== 1'b1; n++)
			@(posedge I_CLOCK);
		#1;
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Sampled mid-cycle so the registered outputs have settled
	always @(negedge I_CLOCK) begin
		cyc <= cyc + 1;
		if (I_NRST && rx_v && rx_r && rx_c)
			n_ctl <= n_ctl + 1;
		if (I_NRST && rx_v && rx_r && !rx_c)
			rxq.push_back(rx_d);
		if (I_NRST && tx_w[65:64] == `HDR_CTRL && (tx_w[63:0] ^ {64{tx_w[66]}}) == `SYNC_WORD) begin
			if (gap_on)
				check(67'(cyc - last_sync), 67'h6);
			last_sync <= cyc;
		end
	end
	initial begin
		repeat (90000) @(posedge I_CLOCK);
		n_mismatch++;
		wrap_up();
	end
	initial begin
		repeat (4) @(posedge I_CLOCK);
		I_NRST <= 1'b1;
		#1 check(67'({tx_r, wlock, flock, rx_v}), 67'h8);
		rd_chk(`ADDR_CTRL, 32'h800);
		rd_chk(4'hc, 32'h0);
		wr(`ADDR_CTRL, 32'h6);
		rd_chk(`ADDR_CTRL, 32'h6);
		wait_for(0, 20000);
		check(67'(wlock), 67'h1);
		wait_for(1, 4000);
		check(67'({wlock, flock, lrdy, crc}), 67'he);
		rd_chk(`ADDR_STATUS, 32'h3);
		gap_on = 1'b1;
		wr(`ADDR_EVENTS, 32'hf);
		rd_chk(`ADDR_EVENTS, 32'h0);
		@(posedge I_CLOCK);
		stall <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			I_TX_VALID <= 1'b1;
			I_TX_DATA <= 64'ha5a5_0f0f_3c3c_0000 + 64'(i);
			@(negedge I_CLOCK);
			while (tx_r !== 1'b1)
				@(negedge I_CLOCK);
			@(posedge I_CLOCK);
			stall <= 1'b0;
		end
		I_TX_VALID <= 1'b0;
		for (int n = 0; n < 500 && rxq.size() < 6; n++)
			@(posedge I_CLOCK);
		#1;
		check(67'(rxq.size()), 67'h6);
		foreach (rxq[i])
			check(67'(rxq[i]), 67'(64'ha5a5_0f0f_3c3c_0000 + 64'(i)));
		check(67'(n_ctl > 0), 67'h1);
		check(67'(crc), 67'h0);
		rd_chk(`ADDR_EVENTS, 32'h0);
		$display("loopback data test done");
		// Six corrupted words hit exactly one sync and one state word of a six word frame
		@(posedge I_CLOCK);
		flip <= 1'b1;
		repeat (6) @(posedge I_CLOCK);
		flip <= 1'b0;
		wait_for(2, 40);
		check(67'(crc), 67'h1);
		repeat (30) @(posedge I_CLOCK);
		#1 check(67'({flock, crc}), 67'h2);
		rd_chk(`ADDR_EVENTS, 32'h6);
		$display("corruption test done");
		// Fixed windows may split the bad run, so 31 bad headers are needed to be sure of loss
		@(posedge I_CLOCK);
		brk <= 1'b1;
		repeat (40) @(posedge I_CLOCK);
		brk <= 1'b0;
		#1 check(67'({wlock, flock}), 67'h0);
		wait_for(0, 40000);
		wait_for(1, 4000);
		check(67'(lrdy), 67'h1);
		$display("lock loss test done");
		@(posedge I_CLOCK);
		I_NRST <= 1'b0;
		gap_on = 1'b0;
		repeat (4) @(posedge I_CLOCK);
		I_NRST <= 1'b1;
		#1 check(67'({wlock, flock, lrdy}), 67'h0);
		rd_chk(`ADDR_CTRL, 32'h800);
		$display("reset test done");
		wrap_up();
	end
endmodule // lane_metaframe_pcs_tb
